/* hdl/aac_consts.svh */
`ifndef AAC_CONSTS_SVH
`define AAC_CONSTS_SVH
// Word indices on the register bus; the byte address is four times these.
`define AAC_REG_CTRL 4'h0
`define AAC_REG_SETPT0 4'h1
`define AAC_REG_SETPT1 4'h2
`define AAC_REG_SETPT2 4'h3
`define AAC_REG_FS_LOW 4'h4
`define AAC_REG_FS_MID 4'h5
`define AAC_REG_FS_HIGH 4'h6
`define AAC_REG_STATUS 4'h7
`define AAC_REG_CAL 4'h8
// Control word layout.
`define AAC_CTRL_HIGH_MSB 2
`define AAC_CTRL_TOP_FS_BIT 3
// Mode switch position inside the configuration switch bank.
`define AAC_SW_AUTO_CLEAR_BIT 5
// Reset values.
`define AAC_SP_RST 16'h00c8
`define AAC_FS_LOW_RST 16'h0064
`define AAC_FS_MID_RST 16'h03e8
`define AAC_FS_HIGH_RST 16'h09c4
`define AAC_CAL_RST 16'h0000
`define AAC_FLAGS_RST 3'h1
// Key chords on the three alarm keys.
`define AAC_CHORD_RANGE 3'h5
`define AAC_CHORD_CAL 3'h7
// Timing.
`define AAC_CLK_HZ 64'd20000000
`define AAC_IDLE_TIMEOUT_S 64'd120
`define AAC_BLINK_HALF_MS 64'd500
`endif

/* hdl/aac_pkg.sv */
`default_nettype none
package aac_pkg;
   // Range selection; the order is the order the range chord steps through.
   typedef enum logic [1:0] {
      AAC_RNG_AUTO,
      AAC_RNG_HIGH,
      AAC_RNG_MID,
      AAC_RNG_LOW
   } aac_range_t;

   typedef struct packed {
      logic [4:0] keys_prev;
      logic [2:0] cond_prev;
      logic [2:0] latched;
      logic [2:0] ack;
      logic [2:0] snd;
      logic silence;
      logic edit_act;
      logic [1:0] edit_ch;
      logic cal_act;
      logic [15:0] cal_pend;
      logic [15:0] cal_gain;
      logic [31:0] idle_cnt;
      aac_range_t rsel;
      logic ol_snd;
      logic over_prev;
      logic [31:0] blink_cnt;
      logic blink;
      logic [2:0] high_sel;
      logic top_fs;
      logic [2:0][15:0] sp;
      logic [2:0][15:0] fs;
      logic [2:0] led;
      logic [2:0] relay;
      logic audible;
      logic ovl;
      logic [2:0] rflags;
      logic [31:0] rdata;
      logic waitreq;
   } aac_state_t;
endpackage
`default_nettype wire

/* hdl/aac_annunciator.sv */
`include "aac_consts.svh"
`default_nettype none
// Notes on behaviour
// - Alarm lights LED, sounds horn, trips relay.
// - Idle key press toggles set-point editing.
// - Auto-clear mode drops indications when clear.
// - Auto mode: first press silences, second edits.
// - Silence mutes horn for all channels.
// - Press on a sounding, unsilenced, unacknowledged channel never enters editing.
// - Exit editing into alarm sounds horn.
// - Auto mode: re-entry into alarm re-sounds silenced horn.
// - Manual mode: silence holds until every channel clears.
// - Manual mode latches indications.
// - Manual mode: silence first, then press clears.
// - Manual mode: idle key quiets horn only while editing.
// - Idle editing times out, keeps set point.
// - Calibration timeout discards pending adjustment.
// - Over range blinks overload and sounds horn.
// - Any key or return in range silences.
// - Full-scale top range never shows overload.
// - Range flags are one-hot.
// - Autoranging after reset.
// - Range chord steps high, mid, low, auto.
// - Fixed range over its scale shows overload.
module aac_annunciator
   import aac_pkg::*;
#(
   parameter logic [31:0] IDLE_TIMEOUT_CYC =
      32'(`AAC_IDLE_TIMEOUT_S * `AAC_CLK_HZ),
   parameter logic [31:0] BLINK_HALF_CYC =
      32'(`AAC_BLINK_HALF_MS * `AAC_CLK_HZ / 64'd1000)
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic first_alarm_key,
   input wire logic second_alarm_key,
   input wire logic third_alarm_key,
   input wire logic adj_up_key,
   input wire logic adj_down_key,
   input wire logic [7:0] config_switch_bank,
   input wire logic [15:0] reading,
   output logic [2:0] alarm_led,
   output logic [2:0] alarm_relay,
   output logic audible_alarm,
   output logic overload_indication,
   output logic range_low_flag,
   output logic range_mid_flag,
   output logic range_high_flag
);
   aac_state_t q;
   aac_state_t d;
   logic [2:0] cond;
   logic [2:0] rng_used;
   logic [15:0] fs_used;
   logic over;
   logic auto_mode;

   assign auto_mode = config_switch_bank[`AAC_SW_AUTO_CLEAR_BIT];

   // Each channel compares the reading with its own set point.
   for (genvar g = 0; g < 3; g++) begin : g_cond
      assign cond[g] = q.high_sel[g] ? (reading > q.sp[g]) :
                                       (reading < q.sp[g]);
   end

   // Range in use: autoranging picks the lowest range that holds the
   // reading, otherwise the fixed choice applies.
   always_comb begin
      rng_used = 3'h4;
      case (q.rsel)
         AAC_RNG_LOW: rng_used = 3'h1;
         AAC_RNG_MID: rng_used = 3'h2;
         AAC_RNG_HIGH: rng_used = 3'h4;
         default: begin
            if (reading <= q.fs[0]) begin
               rng_used = 3'h1;
            end else if (reading <= q.fs[1]) begin
               rng_used = 3'h2;
            end
         end
      endcase
      fs_used = rng_used[0] ? q.fs[0] : (rng_used[1] ? q.fs[1] : q.fs[2]);
   end

   // A unit whose top range is full scale has nothing to overload.
   assign over = !q.top_fs && (reading > fs_used);

   // All behaviour is computed here from the present state.
   always_comb begin
      logic [4:0] keys;
      logic [4:0] pressed;
      logic single;
      logic [1:0] sel;
      logic chord_rng;
      logic chord_cal;
      logic adj_up;
      logic adj_down;
      logic adj_any;
      logic timeout;
      keys = {adj_down_key, adj_up_key, third_alarm_key,
              second_alarm_key, first_alarm_key};
      pressed = keys & ~q.keys_prev;
      single = (q.keys_prev == 5'h00) && $onehot(keys);
      sel = keys[0] ? 2'h0 : (keys[1] ? 2'h1 : 2'h2);
      chord_rng = (keys[2:0] == `AAC_CHORD_RANGE) &&
                  (q.keys_prev[2:0] != `AAC_CHORD_RANGE);
      chord_cal = (keys[2:0] == `AAC_CHORD_CAL) &&
                  (q.keys_prev[2:0] != `AAC_CHORD_CAL);
      adj_up = pressed[3] && !keys[4];
      adj_down = pressed[4] && !keys[3];
      adj_any = pressed[3] || pressed[4];
      timeout = (q.idle_cnt >= IDLE_TIMEOUT_CYC - 32'h1);
      d = q;
      d.keys_prev = keys;
      d.cond_prev = cond;

      // Silence re-arms once all is clear; manual mode also needs clears.
      if (cond == 3'h0 && (auto_mode || q.latched == 3'h0)) begin
         d.silence = 1'b0;
      end

      // Clearing presses act first so that a fresh alarm still wins.
      if (single && sel != 2'h3 && !q.cal_act && !keys[3] && !keys[4]) begin
         if (q.edit_act) begin
            if (q.edit_ch == sel) begin
               d.edit_act = 1'b0;
               if (cond[sel]) begin
                  d.snd[sel] = 1'b1;
                  d.silence = 1'b0;
               end
            end
         end else if (auto_mode) begin
            if (cond[sel] && q.snd[sel] && !q.silence && !q.ack[sel]) begin
               d.silence = 1'b1;
               d.ack[sel] = 1'b1;
            end else begin
               d.edit_act = 1'b1;
               d.edit_ch = sel;
               d.idle_cnt = 32'h0;
            end
         end else if (q.latched[sel]) begin
            if (!q.ack[sel]) begin
               d.silence = 1'b1;
               d.ack[sel] = 1'b1;
            end else begin
               d.latched[sel] = 1'b0;
               d.snd[sel] = 1'b0;
               d.ack[sel] = 1'b0;
            end
         end else begin
            d.edit_act = 1'b1;
            d.edit_ch = sel;
            d.idle_cnt = 32'h0;
         end
      end

      // Alarm events per channel; a set always beats a clear.
      for (int i = 0; i < 3; i++) begin
         if (auto_mode) begin
            if (!cond[i]) begin
               d.snd[i] = 1'b0;
               d.ack[i] = 1'b0;
            end
            d.latched[i] = cond[i];
         end else if (cond[i]) begin
            d.latched[i] = 1'b1;
         end
         if (cond[i] && !q.cond_prev[i]) begin
            d.snd[i] = 1'b1;
            if (auto_mode) begin
               d.silence = 1'b0;
               d.ack[i] = 1'b0;
            end
         end
      end

      // Set-point editing: arrows adjust, both together flip low/high.
      if (q.edit_act) begin
         d.idle_cnt = q.idle_cnt + 32'h1;
         if (adj_any) begin
            d.idle_cnt = 32'h0;
         end
         if (keys[3] && keys[4] && adj_any) begin
            d.high_sel[q.edit_ch] = !q.high_sel[q.edit_ch];
         end else if (adj_up) begin
            d.sp[q.edit_ch] = q.sp[q.edit_ch] + 16'h0001;
         end else if (adj_down) begin
            d.sp[q.edit_ch] = q.sp[q.edit_ch] - 16'h0001;
         end
         if (timeout && !adj_any) begin
            d.edit_act = 1'b0;
         end
      end

      // Calibration works on a pending copy so a timeout leaves the gain untouched.
      if (q.cal_act) begin
         d.idle_cnt = q.idle_cnt + 32'h1;
         if (adj_any) begin
            d.idle_cnt = 32'h0;
         end
         if (adj_up) begin
            d.cal_pend = q.cal_pend + 16'h0001;
         end else if (adj_down) begin
            d.cal_pend = q.cal_pend - 16'h0001;
         end
         if (chord_cal) begin
            d.cal_act = 1'b0;
            d.cal_gain = q.cal_pend;
         end else if (timeout && !adj_any) begin
            d.cal_act = 1'b0;
         end
      end else if (chord_cal && !q.edit_act) begin
         d.cal_act = 1'b1;
         d.cal_pend = q.cal_gain;
         d.idle_cnt = 32'h0;
      end

      // Range chord steps auto, high, mid, low and wraps.
      if (chord_rng && !q.edit_act && !q.cal_act) begin
         case (q.rsel)
            AAC_RNG_AUTO: d.rsel = AAC_RNG_HIGH;
            AAC_RNG_HIGH: d.rsel = AAC_RNG_MID;
            AAC_RNG_MID: d.rsel = AAC_RNG_LOW;
            default: d.rsel = AAC_RNG_AUTO;
         endcase
      end

      // Overload horn: any key mutes it, back in range ends it.
      d.over_prev = over;
      if (pressed != 5'h00) begin
         d.ol_snd = 1'b0;
      end
      if (!over) begin
         d.ol_snd = 1'b0;
      end else if (!q.over_prev) begin
         d.ol_snd = 1'b1;
      end

      // Blink divider gives the overload display its flash rate.
      if (q.blink_cnt >= BLINK_HALF_CYC - 32'h1) begin
         d.blink_cnt = 32'h0;
         d.blink = !q.blink;
      end else begin
         d.blink_cnt = q.blink_cnt + 32'h1;
      end

      // Bus slave: one wait cycle, then the request completes.
      if ((avs_read || avs_write) && q.waitreq) begin
         d.waitreq = 1'b0;
         d.rdata = 32'h0;
         if (avs_read) begin
            if (avs_address == `AAC_REG_CTRL) begin
               d.rdata = {28'h0, q.top_fs, q.high_sel};
            end else if (avs_address == `AAC_REG_SETPT0) begin
               d.rdata = {16'h0, q.sp[0]};
            end else if (avs_address == `AAC_REG_SETPT1) begin
               d.rdata = {16'h0, q.sp[1]};
            end else if (avs_address == `AAC_REG_SETPT2) begin
               d.rdata = {16'h0, q.sp[2]};
            end else if (avs_address == `AAC_REG_FS_LOW) begin
               d.rdata = {16'h0, q.fs[0]};
            end else if (avs_address == `AAC_REG_FS_MID) begin
               d.rdata = {16'h0, q.fs[1]};
            end else if (avs_address == `AAC_REG_FS_HIGH) begin
               d.rdata = {16'h0, q.fs[2]};
            end else if (avs_address == `AAC_REG_STATUS) begin
               d.rdata = {14'h0, q.ol_snd, over, q.rsel, q.cal_act,
                          q.edit_ch, q.edit_act, q.silence, q.ack,
                          q.latched, cond};
            end else if (avs_address == `AAC_REG_CAL) begin
               d.rdata = {16'h0, q.cal_gain};
            end
         end
      end else begin
         d.waitreq = 1'b1;
      end
      // Writes land at the edge where waitrequest is seen low.
      if (avs_write && !q.waitreq) begin
         if (avs_address == `AAC_REG_CTRL) begin
            d.high_sel = avs_writedata[`AAC_CTRL_HIGH_MSB:0];
            d.top_fs = avs_writedata[`AAC_CTRL_TOP_FS_BIT];
         end else if (avs_address == `AAC_REG_SETPT0) begin
            d.sp[0] = avs_writedata[15:0];
         end else if (avs_address == `AAC_REG_SETPT1) begin
            d.sp[1] = avs_writedata[15:0];
         end else if (avs_address == `AAC_REG_SETPT2) begin
            d.sp[2] = avs_writedata[15:0];
         end else if (avs_address == `AAC_REG_FS_LOW) begin
            d.fs[0] = avs_writedata[15:0];
         end else if (avs_address == `AAC_REG_FS_MID) begin
            d.fs[1] = avs_writedata[15:0];
         end else if (avs_address == `AAC_REG_FS_HIGH) begin
            d.fs[2] = avs_writedata[15:0];
         end
      end

      // Outputs; in manual mode editing quiets the horn only meanwhile.
      for (int i = 0; i < 3; i++) begin
         d.led[i] = d.latched[i] ||
                    (d.edit_act && d.edit_ch == 2'(i));
      end
      d.relay = d.latched;
      d.audible = ((d.snd != 3'h0) && !d.silence &&
                   !(!auto_mode && d.edit_act)) || d.ol_snd;
      d.ovl = over && q.blink;
      d.rflags = rng_used;
   end

   // State register; reset comes up in autoranging.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.rsel <= AAC_RNG_AUTO;
         q.sp <= {3{`AAC_SP_RST}};
         q.fs <= {`AAC_FS_HIGH_RST, `AAC_FS_MID_RST, `AAC_FS_LOW_RST};
         q.cal_gain <= `AAC_CAL_RST;
         q.rflags <= `AAC_FLAGS_RST;
         q.waitreq <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign avs_readdata = q.rdata;
   assign avs_waitrequest = q.waitreq;
   assign alarm_led = q.led;
   assign alarm_relay = q.relay;
   assign audible_alarm = q.audible;
   assign overload_indication = q.ovl;
   assign range_low_flag = q.rflags[0];
   assign range_mid_flag = q.rflags[1];
   assign range_high_flag = q.rflags[2];

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   // A lone press on channel 0 while it sounds in auto-clear mode.
   sequence press_sounding_s;
      auto_mode && cond[0] && q.snd[0] && !q.silence && !q.ack[0] &&
      !q.edit_act && !q.cal_act && q.keys_prev == 5'h00 &&
      first_alarm_key && !second_alarm_key && !third_alarm_key &&
      !adj_up_key && !adj_down_key;
   endsequence

   sequence chord_range_s;
      first_alarm_key && !second_alarm_key && third_alarm_key &&
      q.keys_prev[2:0] != 3'h5 && !q.edit_act && !q.cal_act;
   endsequence

   relay_follows_a: assert property (
      $past(cond[0]) |-> alarm_relay[0])
      else $error("relay did not follow alarm condition");
   silence_press_a: assert property (
      press_sounding_s |=> q.silence && q.ack[0])
      else $error("first press did not silence");
   no_edit_a: assert property (
      press_sounding_s |=> !q.edit_act)
      else $error("sounding channel entered editing");
   auto_clear_a: assert property (
      auto_mode && !cond[1] ##1 auto_mode && !cond[1] |=> !alarm_relay[1])
      else $error("auto clear left relay on");
   latch_hold_a: assert property (
      !auto_mode && q.latched[2] && !third_alarm_key |=> q.latched[2])
      else $error("manual latch dropped without press");
   flags_onehot_a: assert property (
      $onehot({range_high_flag, range_mid_flag, range_low_flag}))
      else $error("range flags not one-hot");
   range_step_a: assert property (
      chord_range_s ##0 (q.rsel == AAC_RNG_AUTO) |=>
      q.rsel == AAC_RNG_HIGH ##0 $stable(q.cal_gain))
      else $error("range chord did not step to high");
   no_overload_a: assert property (
      $past(q.top_fs) |-> !overload_indication)
      else $error("overload shown on full-scale unit");
   cal_discard_a: assert property (
      q.cal_act && q.idle_cnt >= IDLE_TIMEOUT_CYC - 32'h1 &&
      !adj_up_key && !adj_down_key && !(first_alarm_key &&
      second_alarm_key && third_alarm_key) |=>
      !q.cal_act && $stable(q.cal_gain))
      else $error("calibration timeout changed gain");
   edit_timeout_a: assert property (
      q.edit_act && q.idle_cnt >= IDLE_TIMEOUT_CYC - 32'h1 &&
      !adj_up_key && !adj_down_key && q.keys_prev[4:3] == 2'h0 |=>
      !q.edit_act ##0 $stable(q.sp))
      else $error("editing did not time out");
endmodule
`default_nettype wire

/* test/aac_panel_model.sv */
`default_nettype none
// Front-panel stand-in: five push-buttons that a person presses and lets go.
module aac_panel_model (
   input wire logic ref_clk,
   output logic [4:0] keys
);
   timeunit 1ns;
   timeprecision 1ns;

   // Bits are first, second and third alarm key, then up and down arrow.
   initial begin
      keys = 5'h00;
   end

   // A press lasts one cycle and every key is low again before the next
   // call, so each call is seen as a fresh press and never as a held key.
   task automatic press(input logic [4:0] k);
      @(posedge ref_clk);
      keys <= k;
      @(posedge ref_clk);
      keys <= 5'h00;
      @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
`default_nettype none
`define TB_CHK(nm, exp, got) begin cmp_count++; \
   if ((got) !== (exp)) begin errors++; \
   $display("[ERR] %s exp %h got %h", nm, exp, got); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int IDLE = 50;
   localparam int BLINK = 4;
   logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, d;
   logic [4:0] keys;
   logic [7:0] sw;
   logic [15:0] reading;
   logic [2:0] led, relay;
   logic audible, ovl, rlo, rmid, rhi, o1;
   int errors, cmp_count;
   const logic [31:0] rst_v [9] = '{32'h0, 32'hc8, 32'hc8, 32'hc8, 32'h64,
      32'h3e8, 32'h9c4, 32'h0, 32'h0};

   aac_annunciator #(.IDLE_TIMEOUT_CYC(IDLE), .BLINK_HALF_CYC(BLINK)) i_dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .first_alarm_key(keys[0]),
      .second_alarm_key(keys[1]), .third_alarm_key(keys[2]),
      .adj_up_key(keys[3]), .adj_down_key(keys[4]),
      .config_switch_bank(sw), .reading(reading), .alarm_led(led),
      .alarm_relay(relay), .audible_alarm(audible),
      .overload_indication(ovl), .range_low_flag(rlo),
      .range_mid_flag(rmid), .range_high_flag(rhi));

   aac_panel_model i_panel (.ref_clk(ref_clk), .keys(keys));

   // Free-running 20 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic finish_test;
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Outputs are looked at on the falling edge, well clear of updates.
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   // One bus access; the request stands until waitrequest is seen low.
   task automatic bus(input logic we, input logic [3:0] a,
                      input logic [31:0] wd);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= we;
      avs_read <= !we;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic set_in(input logic [7:0] s, input logic [15:0] r);
      @(posedge ref_clk);
      sw <= s;
      reading <= r;
      cyc(2);
   endtask

   task automatic press(input logic [4:0] k);
      i_panel.press(k);
      cyc(2);
   endtask

   // A hang is cut short long after the sequence should have ended.
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      finish_test();
   end

   initial begin
      rst_b = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      sw = 8'h20;
      reading = 16'h00c8;
      errors = 0;
      cmp_count = 0;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      cyc(1);
      `TB_CHK("flags", 3'b010, {rhi, rmid, rlo})
      `TB_CHK("led", 3'b000, led)
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, 4'(i), 32'h0);
         if (i != 7) `TB_CHK("reg", rst_v[i], d)
         else `TB_CHK("range sel", 2'h0, d[15:14])
      end
      bus(1'b0, 4'hf, 32'h0);
      `TB_CHK("unmapped", 32'h0, d)
      bus(1'b1, 4'h8, 32'h1234);
      bus(1'b0, 4'h8, 32'h0);
      `TB_CHK("cal", 32'h0, d)
      // Auto-clear: several channels alarm, one press mutes the horn.
      set_in(8'h20, 16'h0010);
      `TB_CHK("led", 3'b111, led)
      `TB_CHK("relay", 3'b111, relay)
      `TB_CHK("horn", 1'b1, audible)
      press(5'h01);
      `TB_CHK("horn", 1'b0, audible)
      bus(1'b0, 4'h7, 32'h0);
      `TB_CHK("editing", 1'b0, d[10])
      set_in(8'h20, 16'h00c8);
      `TB_CHK("led", 3'b000, led)
      `TB_CHK("relay", 3'b000, relay)
      set_in(8'h20, 16'h0010);
      `TB_CHK("horn", 1'b1, audible)
      press(5'h01);
      `TB_CHK("horn", 1'b0, audible)
      press(5'h01);
      bus(1'b0, 4'h7, 32'h0);
      `TB_CHK("edit ch0", 3'b001, d[12:10])
      press(5'h01);
      `TB_CHK("horn", 1'b1, audible)
      set_in(8'h20, 16'h00c8);
      // Idle channel edits at once; raising its set point trips it.
      press(5'h02);
      `TB_CHK("led", 3'b010, led)
      bus(1'b0, 4'h7, 32'h0);
      `TB_CHK("edit ch1", 3'b011, d[12:10])
      press(5'h08);
      press(5'h02);
      `TB_CHK("horn", 1'b1, audible)
      `TB_CHK("led", 3'b010, led)
      bus(1'b0, 4'h2, 32'h0);
      `TB_CHK("setpt1", 32'h00c9, d)
      bus(1'b1, 4'h2, 32'hffff_00c8);
      bus(1'b0, 4'h2, 32'h0);
      `TB_CHK("setpt1", 32'h00c8, d)
      cyc(2);
      `TB_CHK("led", 3'b000, led)
      `TB_CHK("horn", 1'b0, audible)
      // Editing left alone falls back to measuring.
      press(5'h04);
      cyc(IDLE - 10);
      `TB_CHK("led", 3'b100, led)
      cyc(20);
      `TB_CHK("led", 3'b000, led)
      bus(1'b0, 4'h3, 32'h0);
      `TB_CHK("setpt2", 32'h00c8, d)
      bus(1'b1, 4'h0, 32'h4);
      set_in(8'h20, 16'h00c9);
      `TB_CHK("led", 3'b100, led)
      set_in(8'h20, 16'h00c8);
      bus(1'b1, 4'h0, 32'h0);
      // Manual clear keeps indications until silenced and cleared.
      set_in(8'h00, 16'h0010);
      set_in(8'h00, 16'h00c8);
      `TB_CHK("led", 3'b111, led)
      `TB_CHK("relay", 3'b111, relay)
      `TB_CHK("horn", 1'b1, audible)
      press(5'h01);
      `TB_CHK("horn", 1'b0, audible)
      `TB_CHK("relay", 3'b111, relay)
      press(5'h01);
      `TB_CHK("relay", 3'b110, relay)
      `TB_CHK("led", 3'b110, led)
      // Over range: blink and horn, muted by any key or by return.
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      set_in(8'h20, 16'h09c5);
      `TB_CHK("horn", 1'b1, audible)
      o1 = ovl;
      cyc(BLINK);
      `TB_CHK("blink", ~o1, ovl)
      press(5'h08);
      `TB_CHK("horn", 1'b0, audible)
      set_in(8'h20, 16'h09c4);
      `TB_CHK("ovl", 1'b0, ovl)
      set_in(8'h20, 16'h09c5);
      `TB_CHK("horn", 1'b1, audible)
      set_in(8'h20, 16'h09c4);
      `TB_CHK("horn", 1'b0, audible)
      bus(1'b1, 4'h0, 32'h8);
      set_in(8'h20, 16'h09c5);
      cyc(BLINK);
      `TB_CHK("ovl", 1'b0, ovl)
      `TB_CHK("horn", 1'b0, audible)
      bus(1'b1, 4'h0, 32'h0);
      set_in(8'h20, 16'h00c8);
      // Range chord steps high, middle, low, auto.
      for (int i = 1; i <= 4; i++) begin
         press(5'h05);
         bus(1'b0, 4'h7, 32'h0);
         `TB_CHK("range", 2'(i % 4), d[15:14])
         if (i < 4) `TB_CHK("flags", 3'b100 >> (i - 1), {rhi, rmid, rlo})
         if (i == 3) begin
            set_in(8'h20, 16'h0065);
            bus(1'b0, 4'h7, 32'h0);
            `TB_CHK("over", 1'b1, d[16])
            set_in(8'h20, 16'h00c8);
         end
      end
      // Calibration: a timeout drops the pending step, the chord commits.
      press(5'h07);
      press(5'h08);
      bus(1'b0, 4'h7, 32'h0);
      `TB_CHK("cal mode", 1'b1, d[13])
      cyc(IDLE + 10);
      bus(1'b0, 4'h7, 32'h0);
      `TB_CHK("cal mode", 1'b0, d[13])
      bus(1'b0, 4'h8, 32'h0);
      `TB_CHK("cal", 32'h0, d)
      press(5'h07);
      press(5'h08);
      press(5'h07);
      bus(1'b0, 4'h8, 32'h0);
      `TB_CHK("cal", 32'h1, d)
      finish_test();
   end
endmodule
`default_nettype wire
